// *** src/pos_sequencer.sv ***
// Main output, input-OK and power-OK sequencer of a front-end supply.
module pos_sequencer
  import pos_pkg::*;
#(
  parameter int unsigned TICK_CYC    = TICK_CYCLES,
  parameter int unsigned INOK_ST_MS  = INOK_START_DLY_MS,
  parameter int unsigned INOK_DIP_MS = INOK_DIP_DLY_MS,
  parameter int unsigned ON_MS       = ON_DLY_MS,
  parameter int unsigned OFFH_MS     = OFF_HOLD_MS,
  parameter int unsigned PG_MS       = PGOOD_DLY_MS
) (
  input  wire logic               CLOCK_I,
  input  wire logic               SYS_RST_I,
  input  wire logic               MAIN_KILL_N_I,
  input  wire logic               OUTPUT_ENABLE_N_I,
  input  wire logic               INPUT_IN_RANGE_I,
  input  wire logic               INPUT_LOSS_WARN_I,
  input  wire logic               MAIN_IN_REG_I,
  input  wire logic               STBY_IN_REG_I,
  input  wire logic               INT_FAULT_I,
  input  wire logic               SENSE_SHORT_I,
  input  wire logic [TRIM_W-1:0]  OWN_CURRENT_I,
  input  wire logic [TRIM_W-1:0]  SHARE_BUS_LEVEL_I,
  output logic                    MAIN_OUTPUT_EN_O,
  output logic                    STBY_OUTPUT_EN_O,
  output logic                    INPUT_OK_N_O,
  output logic                    POWER_OK_N_O,
  output logic                    SHARE_BUS_CONNECT_O,
  output logic                    SHARE_MASTER_O,
  output logic [TRIM_W-1:0]       SHARE_TRIM_MV_O,
  output logic                    FAULT_LATCHED_O
);

  localparam logic [TRIM_W-1:0] TRIM_MAX = TRIM_W'(TRIM_MAX_MV);

  logic       tick;
  logic       kill_n_s;
  logic       en_n_s;
  logic       en_n_d_reg;
  pos_state_e state_reg;
  logic [MS_W-1:0] seq_ms_reg;
  logic [MS_W-1:0] inok_ms_reg;
  logic [MS_W-1:0] pg_ms_reg;
  logic       inok_seen_reg;
  logic       inok_n_reg;
  logic       pg_n_reg;
  logic       fault_reg;
  logic       main_en_reg;
  logic       main_en_next;
  logic       master_reg;
  logic [TRIM_W-1:0] trim_reg;
  logic       en_toggle;
  logic       run_ok;

  pos_tick #(
    .CYCLES (TICK_CYC)
  ) u_tick (
    .clk_i  (CLOCK_I),
    .rst_i  (SYS_RST_I),
    .tick_o (tick)
  );

  pos_sync #(
    .RST_VAL (1'b0)
  ) u_kill_sync (
    .clk_i (CLOCK_I),
    .rst_i (SYS_RST_I),
    .d_i   (MAIN_KILL_N_I),
    .q_o   (kill_n_s)
  );

  // The enable pin floats high through its pull-up, so reset reads disabled.
  pos_sync #(
    .RST_VAL (1'b1)
  ) u_en_sync (
    .clk_i (CLOCK_I),
    .rst_i (SYS_RST_I),
    .d_i   (OUTPUT_ENABLE_N_I),
    .q_o   (en_n_s)
  );

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      en_n_d_reg <= 1'b1;
    end else begin
      en_n_d_reg <= en_n_s;
    end
  end

  assign en_toggle = (en_n_s != en_n_d_reg);

  // Main output may run only with kill held low, enable low, input good.
  assign run_ok = !kill_n_s && !en_n_s && INPUT_IN_RANGE_I
                  && !fault_reg;

  // Faults latch until the enable pin changes level.
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      fault_reg <= 1'b0;
    end else if (INT_FAULT_I || SENSE_SHORT_I) begin
      fault_reg <= 1'b1;
    end else if (en_toggle) begin
      fault_reg <= 1'b0;
    end
  end

  // Output sequencing: off hold, wait for enable, turn-on delay, run.
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      state_reg  <= POS_OFF_HOLD;
      seq_ms_reg <= MS_ZERO;
    end else begin
      unique case (state_reg)
        POS_OFF_HOLD: begin
          if (tick) begin
            seq_ms_reg <= seq_ms_reg + 1'b1;
          end
          if (seq_ms_reg >= MS_W'(OFFH_MS)) begin
            state_reg  <= fault_reg ? POS_FAULT : POS_IDLE;
            seq_ms_reg <= MS_ZERO;
          end
        end
        POS_IDLE: begin
          if (run_ok) begin
            state_reg  <= POS_ON_WAIT;
            seq_ms_reg <= MS_ZERO;
          end else if (fault_reg) begin
            state_reg <= POS_FAULT;
          end
        end
        POS_ON_WAIT: begin
          if (!run_ok) begin
            state_reg  <= POS_IDLE;
            seq_ms_reg <= MS_ZERO;
          end else begin
            if (tick) begin
              seq_ms_reg <= seq_ms_reg + 1'b1;
            end
            if (seq_ms_reg >= MS_W'(ON_MS)) begin
              state_reg <= POS_ON;
            end
          end
        end
        POS_ON: begin
          if (!run_ok || INPUT_LOSS_WARN_I) begin
            // Off at once: well inside the disable limit.
            state_reg  <= POS_OFF_HOLD;
            seq_ms_reg <= MS_ZERO;
          end
        end
        POS_FAULT: begin
          if (!fault_reg) begin
            state_reg  <= POS_IDLE;
            seq_ms_reg <= MS_ZERO;
          end
        end
        default: begin
          state_reg  <= POS_OFF_HOLD;
          seq_ms_reg <= MS_ZERO;
        end
      endcase
    end
  end

  // Power-OK and the share logic follow this same next value, so power-OK
  // can never outlast the main output by a cycle.
  assign main_en_next = (state_reg == POS_ON) && run_ok
                        && !INPUT_LOSS_WARN_I;

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      main_en_reg <= 1'b0;
    end else begin
      main_en_reg <= main_en_next;
    end
  end

  // Input-OK: first assertion uses the start-up delay, later ones the dip one.
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      inok_ms_reg   <= MS_ZERO;
      inok_n_reg    <= 1'b1;
      inok_seen_reg <= 1'b0;
    end else if (!INPUT_IN_RANGE_I || INPUT_LOSS_WARN_I) begin
      // The loss warning arrives ahead of hold-up end by the lead margin.
      inok_ms_reg <= MS_ZERO;
      inok_n_reg  <= 1'b1;
    end else if (inok_n_reg) begin
      if (tick) begin
        inok_ms_reg <= inok_ms_reg + 1'b1;
      end
      if (inok_ms_reg >= (inok_seen_reg ? MS_W'(INOK_DIP_MS)
                                        : MS_W'(INOK_ST_MS))) begin
        inok_n_reg    <= 1'b0;
        inok_seen_reg <= 1'b1;
      end
    end
  end

  // Power-OK: delayed after regulation, dropped the next cycle on loss.
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      pg_ms_reg <= MS_ZERO;
      pg_n_reg  <= 1'b1;
    end else if (!main_en_next || !MAIN_IN_REG_I || !STBY_IN_REG_I
                 || fault_reg) begin
      pg_ms_reg <= MS_ZERO;
      pg_n_reg  <= 1'b1;
    end else if (pg_n_reg) begin
      if (tick) begin
        pg_ms_reg <= pg_ms_reg + 1'b1;
      end
      if (pg_ms_reg >= MS_W'(PG_MS)) begin
        pg_n_reg <= 1'b0;
      end
    end
  end

  // Share master is whoever meets or exceeds the bus; slaves trim up, capped.
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      master_reg <= 1'b0;
      trim_reg   <= '0;
    end else if (!main_en_next || fault_reg) begin
      master_reg <= 1'b0;
      trim_reg   <= '0;
    end else if (OWN_CURRENT_I >= SHARE_BUS_LEVEL_I) begin
      master_reg <= 1'b1;
      trim_reg   <= '0;
    end else begin
      master_reg <= 1'b0;
      if (tick && trim_reg < TRIM_MAX) begin
        trim_reg <= trim_reg + 1'b1;
      end
    end
  end

  assign MAIN_OUTPUT_EN_O    = main_en_reg;
  assign STBY_OUTPUT_EN_O    = 1'b1;
  assign INPUT_OK_N_O        = inok_n_reg;
  assign POWER_OK_N_O        = pg_n_reg;
  assign SHARE_BUS_CONNECT_O = main_en_reg && !fault_reg;
  assign SHARE_MASTER_O      = master_reg;
  assign SHARE_TRIM_MV_O     = trim_reg;
  assign FAULT_LATCHED_O     = fault_reg;

  // Checks.
  property p_kill_off;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
      kill_n_s |=> !MAIN_OUTPUT_EN_O;
  endproperty
  a_kill_off: assert property (p_kill_off)
    else $error("kill ignored");

  property p_stby;
    @(posedge CLOCK_I) disable iff (SYS_RST_I) STBY_OUTPUT_EN_O;
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby off");

  property p_inok_range;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
      !INPUT_IN_RANGE_I |=> INPUT_OK_N_O;
  endproperty
  a_inok_range: assert property (p_inok_range)
    else $error("inok bad");

  property p_en_off;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
      en_n_s |=> ##1 !MAIN_OUTPUT_EN_O;
  endproperty
  a_en_off: assert property (p_en_off)
    else $error("enable off slow");

  property p_pg_reg;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
      !POWER_OK_N_O |-> MAIN_OUTPUT_EN_O;
  endproperty
  a_pg_reg: assert property (p_pg_reg)
    else $error("pok without main");

  property p_pg_drop;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
      !MAIN_IN_REG_I |=> POWER_OK_N_O;
  endproperty
  a_pg_drop: assert property (p_pg_drop)
    else $error("pok late drop");

  property p_share;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
      SHARE_BUS_CONNECT_O |-> MAIN_OUTPUT_EN_O && !FAULT_LATCHED_O;
  endproperty
  a_share: assert property (p_share)
    else $error("share connected");

  property p_trim;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
      SHARE_TRIM_MV_O <= TRIM_MAX;
  endproperty
  a_trim: assert property (p_trim)
    else $error("trim too high");

  property p_sense;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
      SENSE_SHORT_I |=> FAULT_LATCHED_O ##1 !MAIN_OUTPUT_EN_O;
  endproperty
  a_sense: assert property (p_sense)
    else $error("sense ignored");

  property p_pg_stby;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
      !STBY_IN_REG_I |=> POWER_OK_N_O;
  endproperty
  a_pg_stby: assert property (p_pg_stby)
    else $error("pok without standby");

  property p_pg_fault;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
      FAULT_LATCHED_O |=> POWER_OK_N_O;
  endproperty
  a_pg_fault: assert property (p_pg_fault)
    else $error("pok during fault");

  property p_warn_off;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
      INPUT_LOSS_WARN_I |=> INPUT_OK_N_O && !MAIN_OUTPUT_EN_O;
  endproperty
  a_warn_off: assert property (p_warn_off)
    else $error("inok kept on input loss");

  sequence s_fault_seen;
    FAULT_LATCHED_O;
  endsequence

  sequence s_share_off;
    !SHARE_BUS_CONNECT_O && !SHARE_MASTER_O;
  endsequence

  property p_int_fault;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
      INT_FAULT_I |=> s_fault_seen ##1 s_share_off;
  endproperty
  a_int_fault: assert property (p_int_fault)
    else $error("share kept on fault");

  // Checker helper: ticks spent off, counted only as far as the hold needs.
  logic [MS_W-1:0] chk_off_ms_reg;

  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I || MAIN_OUTPUT_EN_O) begin
      chk_off_ms_reg <= MS_ZERO;
    end else if (tick && chk_off_ms_reg < MS_W'(OFFH_MS)) begin
      chk_off_ms_reg <= chk_off_ms_reg + 1'b1;
    end
  end

  property p_off_hold;
    @(posedge CLOCK_I) disable iff (SYS_RST_I)
      $rose(MAIN_OUTPUT_EN_O) |-> chk_off_ms_reg >= MS_W'(OFFH_MS);
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("restart inside off hold");

endmodule

// *** src/pos_pkg.sv ***
// Constants and types shared by the output sequencer files.
//
// Behaviour
// - Kill input released switches main output off
// - Standby output stays enabled regardless of kill
// - Auto start when input good and enabled
// - Input-OK asserted only while input in range
// - Input-OK within 1800 ms start, 100 ms dip
// - Input-OK drops 7 ms before hold-up ends
// - Main output held off 1000 to 1200 ms
// - Output enable is active low, pulled up
// - Toggling output enable clears latched faults
// - Main output on 190 to 220 ms after enable
// - Main output off within 100 ms of disable
// - Power-OK only while both outputs regulate
// - Power-OK 250 to 350 ms after regulation
// - Power-OK drops within 5 ms of falling
// - Share bus disconnected on fault or off
// - Highest current unit is master, others trim
// - Slave voltage trim limited to +250 mV
// - Sense short shuts the main output down, standby stays on
// - Power-OK held off in standby or fault
package pos_pkg;

  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned TICK_MS         = 1;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;

  // Millisecond figures, each a count of ticks.
  localparam int unsigned INOK_ON_START_MS = 1800;
  localparam int unsigned INOK_ON_DIP_MS   = 100;
  localparam int unsigned INOK_LEAD_MS     = 7;
  localparam int unsigned OFF_MIN_MS       = 1000;
  localparam int unsigned OFF_MAX_MS       = 1200;
  localparam int unsigned ON_DLY_MIN_MS    = 190;
  localparam int unsigned ON_DLY_MAX_MS    = 220;
  localparam int unsigned OFF_DLY_MAX_MS   = 100;
  localparam int unsigned PGOOD_MIN_MS     = 250;
  localparam int unsigned PGOOD_MAX_MS     = 350;
  localparam int unsigned PGOOD_OFF_MAX_MS = 5;

  // Chosen points inside each window.
  localparam int unsigned INOK_START_DLY_MS = 1000;
  localparam int unsigned INOK_DIP_DLY_MS   = 50;
  localparam int unsigned ON_DLY_MS         = 200;
  localparam int unsigned OFF_HOLD_MS       = 1100;
  localparam int unsigned PGOOD_DLY_MS      = 300;

  localparam int unsigned TRIM_MAX_MV   = 250;
  localparam int unsigned TRIM_W        = 9;
  localparam int unsigned MS_W          = 12;

  localparam logic [MS_W-1:0] MS_ZERO = 12'h000;

  typedef enum logic [2:0] {
    POS_OFF_HOLD,
    POS_IDLE,
    POS_ON_WAIT,
    POS_ON,
    POS_FAULT
  } pos_state_e;

endpackage

// *** src/pos_tick.sv ***
// Divider that makes the one-cycle millisecond tick.
module pos_tick
  import pos_pkg::*;
#(
  parameter int unsigned CYCLES = TICK_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);

  logic [$clog2(CYCLES)-1:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i || tick_o) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign tick_o = (cnt_reg == ($clog2(CYCLES))'(CYCLES - 1));

endmodule

// *** src/pos_sync.sv ***
// Two-flop synchroniser for one level.
module pos_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_reg;
  logic q_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= RST_VAL;
      q_reg    <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_reg    <= meta_reg;
    end
  end

  assign q_o = q_reg;

endmodule

// *** sim/pos_pdu_model.sv ***
// Distribution controller and output stage model facing the sequencer.
module pos_pdu_model (
  input  wire logic clk_i,
  input  wire logic main_en_i,
  input  wire logic stby_en_i,
  input  wire logic stby_drop_i,
  input  wire logic want_on_i,
  input  wire logic unplug_i,
  output logic      main_kill_n_o,
  output logic      output_enable_n_o,
  output logic      main_in_reg_o,
  output logic      stby_in_reg_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] ramp_reg;

  // The rail takes a few cycles to settle, so regulation lags the enable.
  always_ff @(posedge clk_i) begin
    ramp_reg <= {ramp_reg[1:0], main_en_i};
  end

  assign main_in_reg_o = (&ramp_reg) & main_en_i;
  // A standby sag can be forced to show power-OK following both rails.
  assign stby_in_reg_o = stby_en_i & ~stby_drop_i;
  // Pulled to ground while seated; withdrawal lets the pin rise.
  assign main_kill_n_o = unplug_i;
  // Faults are cleared as soon as the request is taken away; bringing it back restarts.
  assign output_enable_n_o = ~want_on_i;
endmodule

// *** sim/test_psu_output_sequencer.sv ***
// Self-checking bench for the output sequencer with scaled timing.
module test_psu_output_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import pos_pkg::*;

  localparam int TK = 4, ST = 4, DIP = 3, ON = 5, OFFH = 8, PG = 6;
  localparam int RESTART = (OFFH + ON + 1) * TK + 12;

  logic clk = 1'b0, rst = 1'b1, range_ok = 1'b1, warn = 1'b0;
  logic int_fault = 1'b0, sense_short = 1'b0, want_on = 1'b1;
  logic unplug = 1'b0, stby_drop = 1'b0, kill_n, enable_n, main_reg, stby_reg;
  logic [TRIM_W-1:0] own_cur = 9'h000, bus_lvl = 9'h000, trim;
  logic main_en, stby_en, inok_n, pok_n, connect, master, fault;
  int   miscompares = 0, check_count = 0, n, m;

  always #25 clk = ~clk;

  pos_sequencer #(.TICK_CYC(TK), .INOK_ST_MS(ST), .INOK_DIP_MS(DIP),
    .ON_MS(ON), .OFFH_MS(OFFH), .PG_MS(PG)) pos_sequencer_i (
    .CLOCK_I(clk), .SYS_RST_I(rst), .MAIN_KILL_N_I(kill_n),
    .OUTPUT_ENABLE_N_I(enable_n), .INPUT_IN_RANGE_I(range_ok),
    .INPUT_LOSS_WARN_I(warn), .MAIN_IN_REG_I(main_reg),
    .STBY_IN_REG_I(stby_reg), .INT_FAULT_I(int_fault),
    .SENSE_SHORT_I(sense_short), .OWN_CURRENT_I(own_cur),
    .SHARE_BUS_LEVEL_I(bus_lvl), .MAIN_OUTPUT_EN_O(main_en),
    .STBY_OUTPUT_EN_O(stby_en), .INPUT_OK_N_O(inok_n),
    .POWER_OK_N_O(pok_n), .SHARE_BUS_CONNECT_O(connect),
    .SHARE_MASTER_O(master), .SHARE_TRIM_MV_O(trim),
    .FAULT_LATCHED_O(fault));

  pos_pdu_model pos_pdu_model_i (
    .clk_i(clk), .main_en_i(main_en), .stby_en_i(stby_en),
    .stby_drop_i(stby_drop),
    .want_on_i(want_on), .unplug_i(unplug), .main_kill_n_o(kill_n),
    .output_enable_n_o(enable_n), .main_in_reg_o(main_reg),
    .stby_in_reg_o(stby_reg));

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [TRIM_W-1:0] got,
                         input logic [TRIM_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h to %h", $time, got, lo, hi);
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return main_en;
      1: return inok_n;
      2: return pok_n;
      default: return fault;
    endcase
  endfunction

  // Every wait is bounded; running out ends the run as a mismatch.
  task automatic wait_lvl(input int sel, input logic val, input int lim,
                          output int cnt);
    // Look a moment after the edge so freshly launched outputs are settled.
    #1;
    cnt = 0;
    while (pick(sel) !== val && cnt < lim) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    check_count++;
    if (pick(sel) !== val) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, pick(sel), val);
      close_out();
    end
  endtask

  task automatic t_reset();
    chk_bit(main_en, 1'b0);
    chk_bit(stby_en, 1'b1);
    chk_bit(inok_n, 1'b1);
    chk_bit(pok_n, 1'b1);
    chk_bit(connect, 1'b0);
    chk_bit(fault, 1'b0);
    chk_vec(trim, 9'h000);
  endtask

  task automatic t_start();
    wait_lvl(1, 1'b0, (ST + 1) * TK + 8, n);
    wait_lvl(0, 1'b1, RESTART, m);
    chk_rng(n + m, (OFFH + ON - 1) * TK, RESTART);
    wait_lvl(2, 1'b0, (PG + 1) * TK + 8, n);
    chk_rng(n, (PG - 1) * TK, (PG + 1) * TK + 8);
    chk_bit(connect, 1'b1);
  endtask

  task automatic t_stby();
    @(posedge clk) stby_drop <= 1'b1;
    wait_lvl(2, 1'b1, 5 * TK, n);
    chk_bit(main_en, 1'b1);
    @(posedge clk) stby_drop <= 1'b0;
    wait_lvl(2, 1'b0, (PG + 1) * TK + 8, n);
  endtask

  task automatic t_share();
    @(posedge clk) own_cur <= 9'h064;
    bus_lvl <= 9'h032;
    repeat (4) @(posedge clk);
    #1 chk_bit(master, 1'b1);
    chk_vec(trim, 9'h000);
    @(posedge clk) own_cur <= 9'h010;
    repeat (270 * TK) @(posedge clk);
    #1 chk_bit(master, 1'b0);
    chk_vec(trim, 9'h0FA);
  endtask

  task automatic t_disable();
    @(posedge clk) want_on <= 1'b0;
    wait_lvl(0, 1'b0, 10, n);
    wait_lvl(2, 1'b1, 5 * TK, n);
    chk_bit(connect, 1'b0);
    chk_vec(trim, 9'h000);
    @(posedge clk) want_on <= 1'b1;
    wait_lvl(0, 1'b1, RESTART, n);
    chk_rng(n, (OFFH + ON - 1) * TK, RESTART);
    wait_lvl(2, 1'b0, (PG + 1) * TK + 8, n);
  endtask

  task automatic t_kill();
    @(posedge clk) unplug <= 1'b1;
    wait_lvl(0, 1'b0, 10, n);
    chk_bit(stby_en, 1'b1);
    @(posedge clk) unplug <= 1'b0;
    wait_lvl(0, 1'b1, RESTART, n);
  endtask

  task automatic t_fault(input bit by_sense);
    @(posedge clk) int_fault <= !by_sense;
    sense_short <= by_sense;
    @(posedge clk) int_fault <= 1'b0;
    sense_short <= 1'b0;
    wait_lvl(3, 1'b1, 4, n);
    wait_lvl(0, 1'b0, 6, n);
    wait_lvl(2, 1'b1, 5 * TK, n);
    chk_bit(connect, 1'b0);
    repeat ((OFFH + ON + 2) * TK) @(posedge clk);
    #1 chk_bit(main_en, 1'b0);
    chk_bit(fault, 1'b1);
    @(posedge clk) want_on <= 1'b0;
    repeat (4) @(posedge clk);
    want_on <= 1'b1;
    wait_lvl(3, 1'b0, 10, n);
    wait_lvl(0, 1'b1, RESTART, n);
  endtask

  task automatic t_loss();
    @(posedge clk) warn <= 1'b1;
    wait_lvl(1, 1'b1, 3, n);
    wait_lvl(0, 1'b0, 3, n);
    @(posedge clk) range_ok <= 1'b0;
    warn <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk_bit(inok_n, 1'b1);
    @(posedge clk) range_ok <= 1'b1;
    wait_lvl(1, 1'b0, (DIP + 1) * TK + 8, n);
  endtask

  initial begin
    repeat (9) @(posedge clk);
    #1 t_reset();
    @(posedge clk) rst <= 1'b0;
    @(posedge clk);
    #1 t_reset();
    t_start();
    t_stby();
    t_share();
    t_disable();
    t_kill();
    t_fault(1'b0);
    t_fault(1'b1);
    t_loss();
    close_out();
  end
endmodule
